/* logic/tct_defs.vh */
// constants for the translation cache tagging block
// assumes one synchronous clock domain and a single include per file
`ifndef TCT_DEFS_VH
`define TCT_DEFS_VH

// entry store geometry
`define TCT_DEPTH        16
`define TCT_IDX_W        4
`define TCT_SRC_W        16
`define TCT_DID_W        16
`define TCT_PASID_W      20
`define TCT_ADDR_W       64
`define TCT_DATA_W       52

// cache kinds held in the shared store
`define TCT_KIND_CTX     3'h0
`define TCT_KIND_PASID   3'h1
`define TCT_KIND_IO_TRANSLATION_BUFFER   3'h2
`define TCT_KIND_PSC     3'h3
`define TCT_KIND_IEC     3'h4

// level codes: page size or paging-structure level
`define TCT_LVL_LEAF     2'h0
`define TCT_LVL_DIR      2'h1
`define TCT_LVL_THIRD    2'h2
`define TCT_LVL_TOP      2'h3

// address tag bit positions
`define TCT_LO_BASE      7'h0C
`define TCT_LO_STEP      7'h09
`define TCT_FL_TOP_BIT   7'h2F
`define TCT_IDX_BITS     16

// invalidation field selects
`define TCT_INV_SRC      0
`define TCT_INV_DID      1
`define TCT_INV_PASID    2
`define TCT_INV_ADDR     3

// reserved domain tag and caching mode reset value
`define TCT_RSVD_DID     16'h0000
`define TCT_CM_DEFAULT   1'b0

`endif

/* logic/tct_top.v */
// shared tag store for context, pasid, io translation, paging-structure
// and interrupt entry caches; lookup, fill and group invalidation ports
// assumes walk logic fills after a miss and drives one clock domain
//
// Summary of operation
// - caching mode flag output tells whether faulting entries may be cached
// - hardware runs with caching mode flag set from CACHING_MODE parameter, cleared by default
// - context cache holds context entries fetched during walks
// - pasid cache holds pasid table entries for pasid requests
// - translation buffer holds final translation of each request
// - paging-structure caches hold only intermediate walk entries
// - context, translation buffer, interrupt entries tagged with source id
// - paging-structure and pasid entries carry context domain id
// - context and translation buffer entries also carry domain id
// - translation buffer separates pasid and non-pasid entries by type bit
// - paging-structure entries separate first and second level by bit
// - first-level page tag 47:30, 47:21 or 47:12 by page size
// - second-level page tag from guest width down to 30, 21, 12
// - first-level structure tags 47:39, 47:30, 47:21 by level
// - second-level structure tags guest width down to 39, 30, 21
// - pasid request entries tagged with the request pasid
// - interrupt entries tagged with interrupt index
// - one operation invalidates every entry matching a tag value
// - faulting context entry not cached when caching mode clear
// - faulting entry without present context gets domain tag zero
`include "tct_defs.vh"
`default_nettype none

module tct_top #(
	parameter CACHING_MODE = `TCT_CM_DEFAULT
) (
	// clock and reset
	input  wire                        SYS_CLK,
	input  wire                        RST,
	// configuration
	input  wire [5:0]                  MAX_GUEST_ADDR_WIDTH,
	output reg                         CACHING_MODE_FLAG,
	// lookup request
	input  wire                        LKP_VALID,
	input  wire [2:0]                  LKP_KIND,
	input  wire [`TCT_SRC_W-1:0]       LKP_SRC,
	input  wire [`TCT_DID_W-1:0]       LKP_DID,
	input  wire [`TCT_PASID_W-1:0]     LKP_PASID,
	input  wire                        LKP_WITH_PASID,
	input  wire [1:0]                  LKP_LEVEL,
	input  wire [`TCT_ADDR_W-1:0]      LKP_ADDR,
	// lookup answer
	output reg                         LKP_DONE,
	output reg                         LKP_HIT,
	output reg  [`TCT_DATA_W-1:0]      LKP_DATA,
	output reg  [1:0]                  LKP_PAGE_LEVEL,
	// fill from walk logic
	input  wire                        FILL_VALID,
	input  wire [2:0]                  FILL_KIND,
	input  wire [`TCT_SRC_W-1:0]       FILL_SRC,
	input  wire [`TCT_DID_W-1:0]       FILL_DID,
	input  wire [`TCT_PASID_W-1:0]     FILL_PASID,
	input  wire                        FILL_WITH_PASID,
	input  wire [1:0]                  FILL_LEVEL,
	input  wire [`TCT_ADDR_W-1:0]      FILL_ADDR,
	input  wire [`TCT_DATA_W-1:0]      FILL_DATA,
	input  wire                        FILL_FAULT,
	input  wire                        FILL_CTX_PRESENT,
	output reg                         FILL_TAKEN,
	// group invalidation
	input  wire                        INV_VALID,
	input  wire [2:0]                  INV_KIND,
	input  wire [3:0]                  INV_SEL,
	input  wire [`TCT_SRC_W-1:0]       INV_SRC,
	input  wire [`TCT_DID_W-1:0]       INV_DID,
	input  wire [`TCT_PASID_W-1:0]     INV_PASID,
	input  wire [`TCT_ADDR_W-1:0]      INV_ADDR,
	output reg                         INV_DONE,
	output reg  [`TCT_IDX_W:0]         INV_COUNT
);

	// entry store
	reg [`TCT_DEPTH-1:0]   valid_q;
	reg [2:0]              kind_q  [0:`TCT_DEPTH-1];
	reg [`TCT_SRC_W-1:0]   src_q   [0:`TCT_DEPTH-1];
	reg [`TCT_DID_W-1:0]   did_q   [0:`TCT_DEPTH-1];
	reg [`TCT_PASID_W-1:0] pasid_q [0:`TCT_DEPTH-1];
	reg                    wp_q    [0:`TCT_DEPTH-1];
	reg [1:0]              lvl_q   [0:`TCT_DEPTH-1];
	reg [`TCT_ADDR_W-1:0]  addr_q  [0:`TCT_DEPTH-1];
	reg [`TCT_DATA_W-1:0]  data_q  [0:`TCT_DEPTH-1];
	reg [`TCT_IDX_W-1:0]   rr_q;

	reg                    lkp_hit_d;
	reg [`TCT_IDX_W-1:0]   lkp_idx;
	reg                    fill_ok;
	reg                    fill_free;
	reg [`TCT_IDX_W-1:0]   fill_idx;
	reg [`TCT_IDX_W-1:0]   free_idx;
	reg                    fill_match;
	reg [`TCT_DID_W-1:0]   fill_did;
	reg [`TCT_DEPTH-1:0]   kill;
	reg [`TCT_DEPTH-1:0]   valid_d;
	reg [`TCT_IDX_W:0]     kill_cnt;
	reg                    lkp_take;
	// one loop index per process
	integer                i;
	integer                j;
	integer                n;

	// tag bit window from level and walk type
	function [`TCT_ADDR_W-1:0] tag_mask;
		input [1:0] lvl;
		input       first_lvl;
		input [5:0] max_guest_addr_width;
		integer     b;
		reg [6:0]   lo;
		reg [6:0]   hi;
		begin
			lo = `TCT_LO_BASE + `TCT_LO_STEP * {5'h00, lvl};
			hi = first_lvl ? `TCT_FL_TOP_BIT : {1'b0, max_guest_addr_width};
			for (b = 0; b < `TCT_ADDR_W; b = b + 1)
			begin
				tag_mask[b] = (b >= lo) && (b <= hi);
			end
		end
	endfunction

	// masked page number compare
	function addr_eq;
		input [`TCT_ADDR_W-1:0] x;
		input [`TCT_ADDR_W-1:0] y;
		input [`TCT_ADDR_W-1:0] m;
		begin
			addr_eq = (((x ^ y) & m) == {`TCT_ADDR_W{1'b0}});
		end
	endfunction

	// full tag compare of one entry
	function ent_match;
		input integer                e;
		input [2:0]                  k;
		input [`TCT_SRC_W-1:0]       s;
		input [`TCT_DID_W-1:0]       d;
		input [`TCT_PASID_W-1:0]     p;
		input                        w;
		input [1:0]                  l;
		input [`TCT_ADDR_W-1:0]      a;
		reg [`TCT_ADDR_W-1:0]        m;
		reg                          pas_ok;
		begin
			m = tag_mask(lvl_q[e], wp_q[e], MAX_GUEST_ADDR_WIDTH);
			pas_ok = (wp_q[e] == w) && (!w || (pasid_q[e] == p));
			ent_match = 1'b0;
			if (valid_q[e] && (kind_q[e] == k))
			begin
				case (k)
					`TCT_KIND_CTX:
					begin
						ent_match = (src_q[e] == s);
					end
					`TCT_KIND_PASID:
					begin
						ent_match = (did_q[e] == d) && (pasid_q[e] == p);
					end
					`TCT_KIND_IO_TRANSLATION_BUFFER:
					begin
						ent_match = (src_q[e] == s) && pas_ok && addr_eq(addr_q[e], a, m);
					end
					`TCT_KIND_PSC:
					begin
						ent_match = (did_q[e] == d) && pas_ok && (lvl_q[e] == l) &&
							addr_eq(addr_q[e], a, m);
					end
					`TCT_KIND_IEC:
					begin
						ent_match = (src_q[e] == s) &&
							(addr_q[e][`TCT_IDX_BITS-1:0] == a[`TCT_IDX_BITS-1:0]);
					end
					default:
					begin
						ent_match = 1'b0;
					end
				endcase
			end
		end
	endfunction

	// lookup search
	always @*
	begin
		lkp_hit_d = 1'b0;
		lkp_idx = {`TCT_IDX_W{1'b0}};
		for (i = 0; i < `TCT_DEPTH; i = i + 1)
		begin
			if (ent_match(i, LKP_KIND, LKP_SRC, LKP_DID, LKP_PASID, LKP_WITH_PASID,
				LKP_LEVEL, LKP_ADDR))
			begin
				lkp_hit_d = 1'b1;
				lkp_idx = i[`TCT_IDX_W-1:0];
			end
		end
		lkp_take = LKP_VALID && lkp_hit_d;
	end

	// fill admission and slot choice
	always @*
	begin
		// drop faulting entries in mode zero
		fill_ok = FILL_VALID && (!FILL_FAULT || CACHING_MODE_FLAG) &&
			// structure cache takes intermediate levels only
			!((FILL_KIND == `TCT_KIND_PSC) && (FILL_LEVEL == `TCT_LVL_LEAF));
		if (CACHING_MODE_FLAG && FILL_FAULT && !FILL_CTX_PRESENT)
		begin
			fill_did = `TCT_RSVD_DID;
		end
		else
		begin
			fill_did = FILL_DID;
		end
		fill_match = 1'b0;
		fill_free = 1'b0;
		fill_idx = rr_q;
		free_idx = {`TCT_IDX_W{1'b0}};
		for (j = 0; j < `TCT_DEPTH; j = j + 1)
		begin
			if (!valid_q[j] && !fill_free)
			begin
				fill_free = 1'b1;
				free_idx = j[`TCT_IDX_W-1:0];
			end
			if (ent_match(j, FILL_KIND, FILL_SRC, fill_did, FILL_PASID, FILL_WITH_PASID,
				FILL_LEVEL, FILL_ADDR))
			begin
				fill_match = 1'b1;
				fill_idx = j[`TCT_IDX_W-1:0];
			end
		end
		// slot order: same tag, lowest free, victim
		if (!fill_match && fill_free)
		begin
			fill_idx = free_idx;
		end
	end

	always @*
	begin
		kill_cnt = {(`TCT_IDX_W+1){1'b0}};
		for (n = 0; n < `TCT_DEPTH; n = n + 1)
		begin
			kill[n] = INV_VALID && valid_q[n] && (kind_q[n] == INV_KIND) &&
				(!INV_SEL[`TCT_INV_SRC] || (src_q[n] == INV_SRC)) &&
				(!INV_SEL[`TCT_INV_DID] || (did_q[n] == INV_DID)) &&
				(!INV_SEL[`TCT_INV_PASID] || (pasid_q[n] == INV_PASID)) &&
				(!INV_SEL[`TCT_INV_ADDR] || addr_eq(addr_q[n], INV_ADDR,
					tag_mask(lvl_q[n], wp_q[n], MAX_GUEST_ADDR_WIDTH)));
			kill_cnt = kill_cnt + {{`TCT_IDX_W{1'b0}}, kill[n]};
		end
		valid_d = valid_q & ~kill;
		if (fill_ok)
			valid_d[fill_idx] = 1'b1;
	end

	// store update and answers
	always @(posedge SYS_CLK)
	begin
		if (RST)
		begin
			valid_q <= {`TCT_DEPTH{1'b0}};
			rr_q <= {`TCT_IDX_W{1'b0}};
			CACHING_MODE_FLAG <= 1'b0;
			LKP_DONE <= 1'b0;
			LKP_HIT <= 1'b0;
			LKP_DATA <= {`TCT_DATA_W{1'b0}};
			LKP_PAGE_LEVEL <= 2'h0;
			FILL_TAKEN <= 1'b0;
			INV_DONE <= 1'b0;
			INV_COUNT <= {(`TCT_IDX_W+1){1'b0}};
		end
		else
		begin
			CACHING_MODE_FLAG <= (CACHING_MODE != 0);
			valid_q <= valid_d;
			LKP_DONE <= LKP_VALID;
			LKP_HIT <= lkp_take;
			LKP_DATA <= lkp_take ? data_q[lkp_idx] : {`TCT_DATA_W{1'b0}};
			LKP_PAGE_LEVEL <= lkp_take ? lvl_q[lkp_idx] : 2'h0;
			FILL_TAKEN <= fill_ok;
			INV_DONE <= INV_VALID;
			INV_COUNT <= INV_VALID ? kill_cnt : {(`TCT_IDX_W+1){1'b0}};
			if (fill_ok)
			begin
				if (!fill_match && !fill_free)
				begin
					rr_q <= rr_q + {{(`TCT_IDX_W-1){1'b0}}, 1'b1};
				end
				kind_q[fill_idx] <= FILL_KIND;
				data_q[fill_idx] <= FILL_DATA;
				src_q[fill_idx] <= FILL_SRC;
				did_q[fill_idx] <= fill_did;
				pasid_q[fill_idx] <= FILL_WITH_PASID ? FILL_PASID : {`TCT_PASID_W{1'b0}};
				wp_q[fill_idx] <= FILL_WITH_PASID;
				lvl_q[fill_idx] <= FILL_LEVEL;
				addr_q[fill_idx] <= FILL_ADDR;
			end
		end
	end

endmodule

`default_nettype wire

/* verif/tct_top_sva.sv */
// timing checks on lookup, fill and invalidate ports of the tag store
// assumes one clock, reset high, bound onto tct_top
`include "tct_defs.vh"
`default_nettype none
module tct_top_chk (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RST,
	// watched ports
	input wire logic CACHING_MODE_FLAG,
	input wire logic LKP_VALID,
	input wire logic LKP_DONE,
	input wire logic LKP_HIT,
	input wire logic [`TCT_DATA_W-1:0] LKP_DATA,
	input wire logic [1:0] LKP_PAGE_LEVEL,
	input wire logic FILL_VALID,
	input wire logic [2:0] FILL_KIND,
	input wire logic [1:0] FILL_LEVEL,
	input wire logic FILL_FAULT,
	input wire logic FILL_TAKEN,
	input wire logic INV_VALID,
	input wire logic INV_DONE,
	input wire logic [`TCT_IDX_W:0] INV_COUNT
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	sequence good_fill_s;
		FILL_VALID && !FILL_FAULT && FILL_KIND != 3'h3;
	endsequence
	sequence miss_s;
		LKP_DONE && !LKP_HIT;
	endsequence
	lkp_answer_a: assert property (LKP_VALID |=> LKP_DONE)
		else $error("lookup not answered");
	lkp_quiet_a: assert property (!LKP_VALID |=> !LKP_DONE && !LKP_HIT)
		else $error("answer without lookup");
	miss_zero_a: assert property (miss_s |-> LKP_DATA == 0 && LKP_PAGE_LEVEL == 2'h0)
		else $error("miss carries data");
	fault_drop_a: assert property (FILL_VALID && FILL_FAULT |=> !FILL_TAKEN)
		else $error("faulting fill stored");
	leaf_drop_a: assert property (FILL_VALID && FILL_KIND == 3'h3 && FILL_LEVEL == 2'h0
		|=> !FILL_TAKEN)
		else $error("leaf stored in structure cache");
	fill_take_a: assert property (good_fill_s |=> FILL_TAKEN)
		else $error("good fill dropped");
	take_cause_a: assert property (FILL_TAKEN |-> $past(FILL_VALID))
		else $error("fill taken without fill");
	inv_done_a: assert property (INV_VALID |=> INV_DONE && INV_COUNT <= 5'h10)
		else $error("invalidate not answered");
	mode_clear_a: assert property (!CACHING_MODE_FLAG)
		else $error("caching mode set");
endmodule
bind tct_top tct_top_chk chk (.*);
`default_nettype wire

/* verif/tct_walker.sv */
// page-walk stand-in: one fill per walk after a chosen delay
// assumes one walk at a time, started by a one-cycle go pulse
`default_nettype none
module tct_walker (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// walk request
	input wire logic go,
	input wire logic [3:0] dly,
	input wire logic [123:0] req,
	// fill toward the store
	output var logic valid,
	output var logic [123:0] fld
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_q = 4'h0;
	logic busy_q = 1'b0;
	logic [123:0] hold_q = '0;
	assign fld = valid ? hold_q : ~hold_q;
	always @(posedge clk)
	begin
		valid <= !rst && !go && busy_q && cnt_q == 4'h0;
		if (rst)
			busy_q <= 1'b0;
		else if (go)
		begin
			busy_q <= 1'b1;
			cnt_q <= dly;
			hold_q <= req;
		end
		else if (busy_q && cnt_q == 4'h0)
			busy_q <= 1'b0;
		else if (busy_q)
			cnt_q <= cnt_q - 4'h1;
	end
endmodule
`default_nettype wire

/* verif/tct_top_bench.sv */
// self-checking bench for the translation cache tag store
// assumes tct_walker as fill source and a guest width of 38
`default_nettype none
module tct_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [2:0] k; logic w; logic [1:0] l; logic [6:0] b; logic h;} tct_row_t;
	localparam logic [63:0] BASE = 64'h0000_1234_5678_9000;
	tct_row_t rows [16] = '{'{2,1,2,29,1}, '{2,1,2,30,0}, '{2,1,1,20,1}, '{2,1,1,21,0},
		'{2,1,0,12,0}, '{2,1,0,48,1}, '{2,0,0,38,0}, '{2,0,0,39,1}, '{3,1,3,38,1},
		'{3,1,3,39,0}, '{3,0,1,21,0}, '{3,0,1,20,1}, '{0,0,0,0,1}, '{1,1,0,0,1},
		'{4,0,0,3,0}, '{4,0,0,0,1}};
	logic SYS_CLK = 0, RST = 1, LKP_VALID = 0, LKP_WITH_PASID = 0, INV_VALID = 0, go = 0;
	logic [2:0] LKP_KIND = 0, INV_KIND = 0;
	logic [15:0] LKP_SRC = 0, LKP_DID = 0, INV_SRC = 0, INV_DID = 0;
	logic [19:0] LKP_PASID = 0, INV_PASID = 0;
	logic [1:0] LKP_LEVEL = 0;
	logic [63:0] LKP_ADDR = 0, INV_ADDR = 0;
	logic [3:0] INV_SEL = 0, dly = 0;
	logic [123:0] req = 0;
	wire logic [123:0] fld;
	wire logic CACHING_MODE_FLAG, LKP_DONE, LKP_HIT, FILL_TAKEN, INV_DONE, FILL_VALID;
	wire logic FILL_WITH_PASID, FILL_FAULT, FILL_CTX_PRESENT;
	wire logic [51:0] LKP_DATA;
	wire logic [1:0] LKP_PAGE_LEVEL, FILL_LEVEL;
	wire logic [4:0] INV_COUNT;
	wire logic [2:0] FILL_KIND;
	wire logic [15:0] FILL_SRC, FILL_DID;
	wire logic [19:0] FILL_PASID;
	wire logic [63:0] FILL_ADDR;
	int bad_count = 0, compares = 0, cyc = 0;
	tct_row_t r;
	assign {FILL_KIND, FILL_SRC, FILL_DID, FILL_PASID, FILL_WITH_PASID, FILL_LEVEL, FILL_ADDR,
		FILL_FAULT, FILL_CTX_PRESENT} = fld;
	tct_walker pw (.clk(SYS_CLK), .rst(RST), .go(go), .dly(dly), .req(req),
		.valid(FILL_VALID), .fld(fld));
	tct_top dut (.*, .FILL_DATA(FILL_ADDR[63:12]), .MAX_GUEST_ADDR_WIDTH(6'h26));
	always #10 SYS_CLK = ~SYS_CLK;
	task final_report;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input string n, input logic [63:0] e, input logic [63:0] g);
		compares++;
		if (g !== e)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task walk(input logic [2:0] k, input logic w, input logic [1:0] l, input logic [15:0] s,
		input logic f, input logic t);
		@(posedge SYS_CLK);
		req <= {k, s, s, 4'h0, s, w, l, BASE, f, 1'b1};
		go <= 1'b1;
		@(posedge SYS_CLK);
		go <= 1'b0;
		#1;
		while (FILL_VALID !== 1'b1)
		begin
			@(posedge SYS_CLK);
			#1;
		end
		@(posedge SYS_CLK);
		#1 chk("fill taken", t, FILL_TAKEN);
	endtask
	task look(input logic [2:0] k, input logic w, input logic [1:0] l, input logic [63:0] a,
		input logic [15:0] s, input logic h);
		@(posedge SYS_CLK);
		LKP_VALID <= 1'b1;
		{LKP_KIND, LKP_WITH_PASID, LKP_LEVEL, LKP_ADDR, LKP_SRC, LKP_DID} <= {k, w, l, a, s, s};
		LKP_PASID <= {4'h0, s};
		@(posedge SYS_CLK);
		LKP_VALID <= 1'b0;
		#1 chk("hit", h, LKP_HIT);
		chk("data", h ? BASE[63:12] : 52'h0, LKP_DATA);
		chk("done", 1, LKP_DONE);
		chk("level", h ? l : 2'h0, LKP_PAGE_LEVEL);
	endtask
	task inv(input logic [2:0] k, input logic [3:0] sel, input logic [15:0] v,
		input logic [4:0] n);
		@(posedge SYS_CLK);
		INV_VALID <= 1'b1;
		{INV_KIND, INV_SEL, INV_SRC, INV_DID, INV_PASID} <= {k, sel, v, v, 4'h0, v};
		INV_ADDR <= BASE;
		@(posedge SYS_CLK);
		INV_VALID <= 1'b0;
		#1 chk("inv count", n, INV_COUNT);
		chk("inv done", 1, INV_DONE);
	endtask
	always @(posedge SYS_CLK)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			bad_count++;
			final_report;
		end
	end
	initial
	begin
		repeat (5) @(posedge SYS_CLK);
		RST <= 1'b0;
		@(posedge SYS_CLK);
		#1 chk("caching mode", 0, CACHING_MODE_FLAG);
		look(3'h2, 1'b1, 2'h0, BASE, 16'h0, 1'b0);
		$display("reset test done");
		for (int i = 0; i < 16; i++)
		begin
			r = rows[i];
			dly <= (i % 2) ? 4'h7 : 4'h0;
			walk(r.k, r.w, r.l, 16'(i), 1'b0, 1'b1);
			look(r.k, r.w, r.l, BASE ^ (r.b ? 64'h1 << r.b : 64'h0), 16'(i), r.h);
		end
		$display("table test done");
		inv(3'h2, 4'h1, 16'h0, 5'h01);
		inv(3'h2, 4'h0, 16'h0, 5'h07);
		inv(3'h3, 4'h2, 16'h8, 5'h01);
		inv(3'h0, 4'h0, 16'h0, 5'h01);
		inv(3'h3, 4'h8, 16'h0, 5'h03);
		look(3'h0, 1'b0, 2'h0, BASE, 16'hC, 1'b0);
		$display("invalidate test done");
		walk(3'h2, 1'b1, 2'h0, 16'h14, 1'b0, 1'b1);
		look(3'h2, 1'b0, 2'h0, BASE, 16'h14, 1'b0);
		walk(3'h2, 1'b0, 2'h0, 16'h15, 1'b1, 1'b0);
		look(3'h2, 1'b0, 2'h0, BASE, 16'h15, 1'b0);
		walk(3'h3, 1'b1, 2'h0, 16'h16, 1'b0, 1'b0);
		$display("refusal test done");
		@(posedge SYS_CLK);
		RST <= 1'b1;
		repeat (2) @(posedge SYS_CLK);
		RST <= 1'b0;
		look(3'h4, 1'b0, 2'h0, BASE, 16'hF, 1'b0);
		$display("mid reset test done");
		final_report;
	end
endmodule
`default_nettype wire
